// ===== design/sbl_pkg.sv
package sbl_pkg;

   // Frame geometry in serial clock edges, word address step in bytes
   localparam logic [5:0]  ADDR_END   = 6'h20;
   localparam logic [5:0]  HDR_END    = 6'h30;
   localparam logic [31:0] WORD_STEP  = 32'h0000_0004;

   // Command codes
   localparam logic [15:0] CMD_WR_ONE   = 16'h0000;
   localparam logic [15:0] CMD_WR_BURST = 16'h0001;
   localparam logic [15:0] CMD_RD_BURST = 16'h0002;
   localparam logic [15:0] CMD_RD_ONE   = 16'h0003;
   localparam logic [15:0] CMD_PKT_CNT  = 16'h0004;
   localparam logic [15:0] CMD_IV       = 16'h0005;
   localparam logic [15:0] CMD_SIG      = 16'h0006;
   localparam logic [15:0] CMD_BUF      = 16'h0007;
   localparam logic [15:0] CMD_CP_DEC   = 16'h0008;
   localparam logic [15:0] CMD_CP_AUTH  = 16'h0009;
   localparam logic [15:0] CMD_CP_OPT   = 16'h000B;
   localparam logic [15:0] CMD_BLOW     = 16'h000C;
   localparam logic [15:0] CMD_LD_DEC   = 16'h000D;
   localparam logic [15:0] CMD_LD_AUTH  = 16'h000E;
   localparam logic [15:0] CMD_LD_OPT   = 16'h0010;
   localparam logic [15:0] CMD_RD_HOLD  = 16'h0011;
   localparam logic [15:0] CMD_STATUS   = 16'h0012;
   localparam logic [15:0] CMD_UNLOCK   = 16'hDE05;

   // Unlock password words, in order
   localparam logic [31:0] UNLOCK_W1 = 32'h5345_ACBA;
   localparam logic [31:0] UNLOCK_W2 = 32'hACBA_5345;

   // Option fuse positions, used width and reset value
   localparam int OPT_SECURE   = 0;
   localparam int OPT_RD_KEY   = 1;
   localparam int OPT_WR_KEY   = 2;
   localparam int OPT_RD_CTRL  = 5;
   localparam int OPT_WR_CTRL  = 6;
   localparam int OPT_RD_RAM   = 7;
   localparam int OPT_FORCE_IV = 10;
   localparam int OPT_DBG      = 16;
   localparam int OPT_USED_W   = 18;
   localparam logic [17:0] OPT_RESET = 18'h0_0000;

   // Fuse box selector and unlock progress
   typedef enum logic [1:0] {SBL_BOX_DEC, SBL_BOX_AUTH, SBL_BOX_OPT} sbl_box_t;
   typedef enum logic [1:0] {SBL_LOCKED, SBL_HALF, SBL_OPEN} sbl_lock_t;

   // System state reported in the acknowledge word
   typedef struct packed {
      logic       user_reset_flag;
      logic       core_reset_flag;
      logic       watchdog_reset_flag;
      logic       boot_fuse;
      logic       chip_identifier_bit;
      logic       security_module_fuse;
      logic       cipher_disabled;
      logic       cipher_128_fuse;
      logic [1:0] spare_fuses;
   } sbl_sys_t;

   // Internal memory request
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sbl_mem_t;

   // Word handed from the serial side: 0 address, 1 command, 2 data
   typedef struct packed {
      logic [1:0]  idx;
      logic [31:0] word;
   } sbl_ev_t;

endpackage : sbl_pkg

// ===== design/sbl_engine.sv
`timescale 1ns/1ns

// Summary of operation
// - Every frame answered with 32-bit acknowledge word
// - Ack carries signature, cipher and spare bits
// - Ack reports reset causes, boot fuse, chip_identifier_bit
// - Command 0000 writes one word at address
// - Command 0001 writes words at consecutive addresses
// - Commands 0004 to 0006 ignore frame address
// - Packet count keeps low 15 bits only
// - Vector and signature built from four words
// - Buffer loaded, then copied to holding register
// - Command 000C blows fuses from holding register
// - Status bit 0 high while fuse write busy
// - Command 0003 returns one addressed word
// - Command 0002 returns consecutive words per 32 clocks
// - Load holding register, then read with 0011
// - Option box 128 bits, only 0-17 used
// - Option bit 0 selects secure mode
// - Bits 1/2 block key readout/key writes
// - Bits 5/6/7 block option read/write, memory read
// - Bit 10 forces extended signature calculation
// - Bit 16 disables debug access
// - Serial mode 0, clock idles low
// - All frame fields little-endian byte order
module sbl_engine
   import sbl_pkg::*;
#(
   parameter logic [14:0] LOADER_SIGN = 15'h2A55 // Arbitrary signature value
)(
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          sck,
   input  wire logic          cs_n,
   input  wire logic          mosi,
   output logic               miso,
   output sbl_mem_t           mem,
   input  wire logic [31:0]   mem_rdata,
   input  wire sbl_sys_t      sys,
   input  wire logic          fuse_busy,
   input  wire logic [127:0]  dec_key_fuses,
   input  wire logic [127:0]  auth_key_fuses,
   input  wire logic [127:0]  opt_fuses,
   output logic               fuse_blow,
   output sbl_box_t           fuse_box,
   output logic [127:0]       fuse_value,
   output logic [14:0]        pkt_count,
   output logic [127:0]       init_vector,
   output logic [127:0]       expected_sig,
   output logic               secure_mode_fuse,
   output logic               force_extended_signature,
   output logic               debug_lock
);

   // Serial side state, cleared by every deselect
   typedef struct packed {
      logic [5:0]  cnt;     // Header bits taken
      logic        in_data; // Past the command field
      logic [4:0]  dbit;    // Bit within data slot
      logic [1:0]  slot;    // Data slot number, wraps
      logic [31:0] rx_sh;   // Incoming shift register
      logic [15:0] cmd;     // Command as seen by the link
      logic [31:0] tx_w;    // Word being returned
      logic [4:0]  txp;     // Stream position driven next
      logic        tx_on;   // Returning a word now
   } sbl_link_t;

   // Core side state
   typedef struct packed {
      logic         tog_s1;
      logic         tog_s2;
      logic         tog_seen;
      sbl_lock_t    lock;
      logic [31:0]  addr;
      logic [15:0]  cmd;
      logic         first;
      logic [1:0]   wcnt;
      sbl_mem_t     mem;
      logic         rd_pend;
      logic [31:0]  mem_word;
      logic [127:0] buffer;
      logic [127:0] tamper;
      sbl_box_t     box;
      logic [17:0]  opt;
      logic [14:0]  pkt;
      logic [127:0] iv;
      logic [127:0] sig;
      logic [127:0] asm_w;
      logic         blow;
      logic [31:0]  ack;
      logic [31:0]  status;
      logic [127:0] tamper_rd;
   } sbl_core_t;

   // Little-endian byte order on the wire, MSB first within a byte
   function automatic logic [31:0] swap32(input logic [31:0] w);
      swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction : swap32

   // Word bit driven at a given stream position
   function automatic logic [4:0] tx_bit(input logic [4:0] p);
      tx_bit = {p[4:3], 3'h7 - p[2:0]};
   endfunction : tx_bit

   // Word returned in a data slot, chosen by the command
   function automatic logic [31:0] tx_pick(input logic [15:0] c,
                                           input logic [1:0] s,
                                           input logic [31:0] mw,
                                           input logic [31:0] st,
                                           input logic [127:0] tr);
      if (c == CMD_RD_BURST || c == CMD_RD_ONE) begin
         tx_pick = mw;
      end else if (c == CMD_STATUS) begin
         tx_pick = st;
      end else if (c == CMD_RD_HOLD) begin
         tx_pick = tr[{s, 5'h00} +: 32];
      end else begin
         tx_pick = 32'h0000_0000;
      end
   endfunction : tx_pick

   logic [1:0]  rst_sync_r;   // Core reset release stages
   logic        rst_n;        // Released core reset
   logic        link_rst_n;   // Serial side reset, frame scoped
   sbl_link_t   lr, ln;       // Serial side state and next
   sbl_core_t   cs, cn;       // Core state and next
   sbl_ev_t     ev_r, ev_nxt; // Word handed to the core
   logic        tog_r;        // Flips once per handed word
   logic        ev_done;      // A field completed this edge
   logic        miso_r;       // Output bit, changes on falling edge

   // Reset release through two stages
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Deselect ends the frame even though the serial clock stops
   assign link_rst_n = arst_n & ~cs_n;

   // Serial side: sample on rising edge, mode 0 only
   always_comb begin
      ln      = lr;
      ev_done = 1'b0;
      ev_nxt  = ev_r;
      ln.rx_sh = {lr.rx_sh[30:0], mosi};
      if (!lr.in_data) begin
         ln.cnt = lr.cnt + 6'h01;
         ln.txp = lr.txp + 5'h01;
         // First edge of any frame starts the acknowledge word
         if (lr.cnt == 6'h00) begin
            ln.tx_w  = cs.ack;
            ln.txp   = 5'h01;
            ln.tx_on = 1'b1;
         end
         if (ln.cnt == ADDR_END) begin
            ln.tx_on = 1'b0;
            ev_done  = 1'b1;
            ev_nxt   = '{idx: 2'h0, word: swap32(ln.rx_sh)};
         end
         if (ln.cnt == HDR_END) begin
            ln.cmd     = {ln.rx_sh[7:0], ln.rx_sh[15:8]};
            ln.in_data = 1'b1;
            ln.dbit    = 5'h00;
            ln.slot    = 2'h0;
            ln.txp     = 5'h00;
            ln.tx_on   = 1'b1;
            ln.tx_w    = tx_pick(ln.cmd, 2'h0, cs.mem_word, cs.status,
                                 cs.tamper_rd);
            ev_done    = 1'b1;
            ev_nxt     = '{idx: 2'h1, word: {16'h0000, ln.cmd}};
         end
      end else begin
         ln.dbit = lr.dbit + 5'h01;
         ln.txp  = lr.txp + 5'h01;
         // Slot boundary: hand the word over, fetch the next reply
         if (lr.dbit == 5'h1F) begin
            ln.slot = lr.slot + 2'h1;
            ln.txp  = 5'h00;
            ln.tx_w = tx_pick(lr.cmd, ln.slot, cs.mem_word, cs.status,
                              cs.tamper_rd);
            ev_done = 1'b1;
            ev_nxt  = '{idx: 2'h2, word: swap32(ln.rx_sh)};
         end
      end
   end

   // Serial side registers
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lr <= '0;
      end else begin
         lr <= ln;
      end
   end

   // Handed word survives deselect so the toggle never flips spuriously
   always_ff @(posedge sck or negedge arst_n) begin
      if (!arst_n) begin
         ev_r  <= '0;
         tog_r <= 1'b0;
      end else if (ev_done) begin
         ev_r  <= ev_nxt;
         tog_r <= ~tog_r;
      end
   end

   // First returned bit is acknowledge bit 7, reserved zero, so reset
   // value is already correct before the first clock edge
   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         miso_r <= 1'b0;
      end else begin
         miso_r <= lr.tx_on ? lr.tx_w[tx_bit(lr.txp)] : 1'b0;
      end
   end
   assign miso = miso_r;

   // Core side: words arrive 16 or 32 serial clocks apart, so ev_r is
   // long stable when the synchronised toggle is seen. The words read
   // back by the serial side change only between its slot boundaries.
   always_comb begin
      logic       ev;
      logic       open;
      logic [31:0] w;
      cn = cs;
      cn.tog_s1   = tog_r;
      cn.tog_s2   = cs.tog_s1;
      cn.tog_seen = cs.tog_s2;
      ev   = cs.tog_s2 != cs.tog_seen;
      open = cs.lock == SBL_OPEN;
      w    = ev_r.word;
      cn.mem.req = 1'b0;
      cn.blow    = 1'b0;
      cn.rd_pend = cs.mem.req & ~cs.mem.we;
      // Memory answers one cycle after a read request
      if (cs.rd_pend) begin
         cn.mem_word = mem_rdata;
      end
      if (ev) begin
         case (ev_r.idx)
            2'h0: begin
               cn.addr  = w;
               cn.first = 1'b1;
               cn.wcnt  = 2'h0;
               cn.mem_word = 32'h0000_0000;
               // Prefetch before the command is known: the reply must be
               // ready when the command field ends. Costs a spare read.
               if (open && !cs.opt[OPT_RD_RAM]) begin
                  cn.mem = '{req: 1'b1, we: 1'b0, addr: w, wdata: '0};
               end
            end
            2'h1: begin
               cn.cmd = w[15:0];
               if (open) begin
                  case (w[15:0])
                     CMD_CP_DEC, CMD_CP_AUTH: begin
                        if (!cs.opt[OPT_WR_KEY]) begin
                           cn.tamper = cs.buffer;
                           cn.box    = (w[15:0] == CMD_CP_DEC) ?
                                       SBL_BOX_DEC : SBL_BOX_AUTH;
                        end
                     end
                     CMD_CP_OPT: begin
                        if (!cs.opt[OPT_WR_CTRL]) begin
                           cn.tamper = cs.buffer;
                           cn.box    = SBL_BOX_OPT;
                        end
                     end
                     CMD_BLOW: begin
                        cn.blow = 1'b1;
                     end
                     CMD_RD_BURST: begin
                        // Slot 1 latches its reply at the end of slot 0,
                        // so the second word must be fetched right now
                        cn.addr = cs.addr + WORD_STEP;
                        if (!cs.opt[OPT_RD_RAM]) begin
                           cn.mem = '{req: 1'b1, we: 1'b0,
                                      addr: cs.addr + WORD_STEP, wdata: '0};
                        end
                     end
                     CMD_LD_DEC: begin
                        cn.tamper = dec_key_fuses;
                        cn.box    = SBL_BOX_DEC;
                     end
                     CMD_LD_AUTH: begin
                        cn.tamper = auth_key_fuses;
                        cn.box    = SBL_BOX_AUTH;
                     end
                     CMD_LD_OPT: begin
                        cn.tamper = opt_fuses;
                        cn.box    = SBL_BOX_OPT;
                        // Upper option bits carry no meaning
                        cn.opt = opt_fuses[OPT_USED_W-1:0];
                     end
                     default: begin
                        cn.first = cs.first;
                     end
                  endcase
               end
            end
            default: begin
               cn.first = 1'b0;
               if (cs.cmd == CMD_UNLOCK) begin
                  // Wrong password word starts the sequence over
                  if (cs.lock == SBL_LOCKED && w == UNLOCK_W1) begin
                     cn.lock = SBL_HALF;
                  end else if (cs.lock == SBL_HALF && w == UNLOCK_W2) begin
                     cn.lock = SBL_OPEN;
                  end else if (cs.lock != SBL_OPEN) begin
                     cn.lock = SBL_LOCKED;
                  end
               end else if (open) begin
                  case (cs.cmd)
                     CMD_WR_ONE: begin
                        if (cs.first) begin
                           cn.mem = '{req: 1'b1, we: 1'b1,
                                      addr: cs.addr, wdata: w};
                        end
                     end
                     CMD_WR_BURST: begin
                        cn.mem  = '{req: 1'b1, we: 1'b1,
                                    addr: cs.addr, wdata: w};
                        cn.addr = cs.addr + WORD_STEP;
                     end
                     CMD_RD_BURST: begin
                        cn.addr = cs.addr + WORD_STEP;
                        if (!cs.opt[OPT_RD_RAM]) begin
                           cn.mem = '{req: 1'b1, we: 1'b0,
                                      addr: cs.addr + WORD_STEP, wdata: '0};
                        end
                     end
                     CMD_PKT_CNT: begin
                        cn.pkt = w[14:0];
                     end
                     CMD_IV, CMD_SIG, CMD_BUF: begin
                        // First word lands in the low 32 bits
                        cn.asm_w = {w, cs.asm_w[127:32]};
                        cn.wcnt  = cs.wcnt + 2'h1;
                        if (cs.wcnt == 2'h3) begin
                           if (cs.cmd == CMD_IV) begin
                              cn.iv = cn.asm_w;
                           end else if (cs.cmd == CMD_SIG) begin
                              cn.sig = cn.asm_w;
                           end else begin
                              cn.buffer = cn.asm_w;
                           end
                        end
                     end
                     default: begin
                        cn.wcnt = cs.wcnt;
                     end
                  endcase
               end
            end
         endcase
      end
      // Acknowledge word, reserved bits zero
      cn.ack = {LOADER_SIGN, sys.user_reset_flag, sys.core_reset_flag,
                sys.watchdog_reset_flag, sys.boot_fuse,
                sys.chip_identifier_bit, 1'b0, sys.security_module_fuse,
                sys.cipher_disabled, sys.cipher_128_fuse, 6'h00,
                sys.spare_fuses};
      cn.status = {31'h0000_0000, fuse_busy | cs.blow};
      // Holding register readback, gated by the read locks
      if (!open || (cs.box == SBL_BOX_OPT && cs.opt[OPT_RD_CTRL]) ||
          (cs.box != SBL_BOX_OPT && cs.opt[OPT_RD_KEY])) begin
         cn.tamper_rd = '0;
      end else begin
         cn.tamper_rd = cs.tamper;
      end
   end

   // Core registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs      <= '0;
         cs.lock <= SBL_LOCKED;
         cs.box  <= SBL_BOX_DEC;
         cs.opt  <= OPT_RESET;
      end else begin
         cs <= cn;
      end
   end

   // Outputs straight from registers
   assign mem          = cs.mem;
   assign fuse_blow    = cs.blow;
   assign fuse_box     = cs.box;
   assign fuse_value   = cs.tamper;
   assign pkt_count    = cs.pkt;
   assign init_vector  = cs.iv;
   assign expected_sig = cs.sig;
   assign secure_mode_fuse         = cs.opt[OPT_SECURE];
   assign force_extended_signature = cs.opt[OPT_FORCE_IV];
   assign debug_lock               = cs.opt[OPT_DBG];

   logic core_ev;  // Handed word seen this cycle
   assign core_ev = cs.tog_s2 != cs.tog_seen;

   AST_WR_ONE: assert property (@(posedge clk) disable iff (!rst_n)
      core_ev && ev_r.idx == 2'h2 && cs.cmd == CMD_WR_ONE && cs.first &&
      cs.lock == SBL_OPEN |=> mem.req && mem.we && mem.addr == $past(cs.addr))
      else $error("single write not issued");
   AST_WR_BURST: assert property (@(posedge clk) disable iff (!rst_n)
      core_ev && ev_r.idx == 2'h2 && cs.cmd == CMD_WR_BURST &&
      cs.lock == SBL_OPEN |=> mem.we && cs.addr == mem.addr + WORD_STEP)
      else $error("burst write address not stepped");
   AST_PKT: assert property (@(posedge clk) disable iff (!rst_n)
      core_ev && ev_r.idx == 2'h2 && cs.cmd == CMD_PKT_CNT &&
      cs.lock == SBL_OPEN |=> pkt_count == $past(ev_r.word[14:0]))
      else $error("packet count not loaded");
   AST_LOCKED: assert property (@(posedge clk) disable iff (!rst_n)
      cs.lock != SBL_OPEN |=> !(mem.req && mem.we) && !fuse_blow)
      else $error("command acted while locked");
   AST_BLOW: assert property (@(posedge clk) disable iff (!rst_n)
      core_ev && ev_r.idx == 2'h1 && ev_r.word[15:0] == CMD_BLOW &&
      cs.lock == SBL_OPEN |=> fuse_blow ##1 !fuse_blow)
      else $error("blow pulse wrong");
   AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
      core_ev && ev_r.idx == 2'h1 && ev_r.word[15:0] == CMD_LD_OPT &&
      cs.lock == SBL_OPEN |=> ##1 debug_lock == $past(opt_fuses[OPT_DBG], 2))
      else $error("option reload missed");
   AST_RD_RAM: assert property (@(posedge clk) disable iff (!rst_n)
      cs.opt[OPT_RD_RAM] && $stable(cs.opt) |=> !(mem.req && !mem.we))
      else $error("memory read while blocked");
   AST_KEY_WR: assert property (@(posedge clk) disable iff (!rst_n)
      core_ev && ev_r.idx == 2'h1 && ev_r.word[15:0] == CMD_CP_DEC &&
      cs.opt[OPT_WR_KEY] |=> $stable(fuse_value))
      else $error("key copy while write blocked");
   AST_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
      fuse_busy ##1 fuse_busy |-> cs.status == 32'h0000_0001)
      else $error("status busy bit wrong");
   AST_ACK: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 1'b1 |-> cs.ack[31:17] == LOADER_SIGN && cs.ack[7:2] == 6'h00)
      else $error("ack signature wrong");

   COV_UNLOCK: cover property (@(posedge clk) disable iff (!rst_n)
      cs.lock == SBL_HALF ##[1:200] cs.lock == SBL_OPEN);
   COV_BURST: cover property (@(posedge clk) disable iff (!rst_n)
      mem.req && mem.we ##[1:200] mem.req && mem.we);
   COV_BLOW: cover property (@(posedge clk) disable iff (!rst_n) fuse_blow);
   COV_READ: cover property (@(posedge clk) disable iff (!rst_n)
      cs.rd_pend && cs.cmd == CMD_RD_BURST);

endmodule : sbl_engine

// ===== verif/sbl_host.sv
`timescale 1ns/1ns

// Host model: serial master, mode 0, clock low outside frames
// Pins always driven: no external fuse programmer here
module sbl_host (
   output logic        sck,
   output logic        cs_n,
   output logic        mosi,
   input  wire logic   miso
);
   logic [31:0] rx [0:5]; // Slots 0-3 data, 4 acknowledge, 5 command field

   // Deselected with the clock low at start
   initial {sck, cs_n, mosi} = 3'h2;

   // Byte 0 first, MSB first in each byte
   task automatic field(input logic [31:0] w, input int nb, input int s);
      for (int p = 0; p < nb; p++) begin
         mosi = w[8*(p/8)+7-(p%8)];
         #24 sck = 1'b1;
         rx[s][8*(p/8)+7-(p%8)] = miso;
         #24 sck = 1'b0;
      end
   endtask : field

   // Whole frame, n words after the header
   task automatic frame(input logic [31:0] a, input logic [15:0] c,
                        input logic [127:0] d, input int n);
      cs_n = 1'b0;
      #24 field(a, 32, 4);
      field({16'h0000, c}, 16, 5);
      for (int k = 0; k < n; k++) field(d[32*k+:32], 32, k);
      mosi = ~mosi; // A released line must not keep its last bit
      #24 cs_n = 1'b1;
      #600; // Lets the core finish before the next frame
   endtask : frame
endmodule : sbl_host

// ===== verif/sbl_engine_bench.sv
`timescale 1ns/1ns

// Bench: host frames in, memory and fuse boxes answered here
module sbl_engine_bench;
   import sbl_pkg::*;
   localparam logic [14:0]  SIGN = 15'h2A55; // Arbitrary signature value
   localparam logic [127:0] OPTS = 128'h104E7; // Used bits only
   logic         clk = 1'b0;
   logic         arst_n = 1'b0;
   logic         sck, cs_n, mosi, miso, fuse_blow;
   sbl_mem_t     mem;
   logic [31:0]  mem_rdata = 32'h0;
   sbl_sys_t     sys = 10'h2B5; // Mixed flags, spare bits 01
   logic         fuse_busy = 1'b0;
   logic [127:0] dec_key_fuses = 128'h0123_4567_89AB_CDEF_0F0F_F0F0_1357;
   logic [127:0] auth_key_fuses = 128'hC3;
   logic [127:0] opt_fuses = 128'h0;
   sbl_box_t     fuse_box, box;
   logic [127:0] fuse_value, init_vector, expected_sig, blown;
   logic [14:0]  pkt_count;
   logic         secure_mode_fuse, force_extended_signature, debug_lock;
   logic [31:0]  wr_q [$]; // Address, data pairs of memory writes
   logic [31:0]  ack_exp;
   int           n_errors = 0;
   int           checks_done = 0;

   always #50 clk = ~clk;
   assign ack_exp = {SIGN, sys[9:5], 1'b0, sys[4:2], 6'h00, sys[1:0]};

   sbl_engine #(.LOADER_SIGN(SIGN)) DUT (.clk, .arst_n, .sck, .cs_n, .mosi,
      .miso, .mem, .mem_rdata, .sys, .fuse_busy, .dec_key_fuses,
      .auth_key_fuses, .opt_fuses, .fuse_blow, .fuse_box, .fuse_value,
      .pkt_count, .init_vector, .expected_sig, .secure_mode_fuse,
      .force_extended_signature, .debug_lock);
   sbl_host host (.sck, .cs_n, .mosi, .miso);

   // Memory answers the cycle after a request; blows are captured
   always @(posedge clk) begin
      if (mem.req === 1'b1) mem_rdata <= ~mem.addr;
      if (mem.req === 1'b1 && mem.we === 1'b1) wr_q.push_back(mem.addr);
      if (mem.req === 1'b1 && mem.we === 1'b1) wr_q.push_back(mem.wdata);
      if (fuse_blow === 1'b1) blown <= fuse_value;
      if (fuse_blow === 1'b1) box <= fuse_box;
   end

   task automatic chk(input string what, input logic [127:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic test_done;
      if (n_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   // Watchdog well beyond the roughly 140 microseconds of traffic
   initial begin
      #1_000_000;
      n_errors++;
      test_done();
   end

   initial begin
      logic [31:0] ew [6] = '{32'h200, 32'hA1B2C3D4, 32'h204, 32'hF1E2D3C4,
                              32'h300, 32'h5A5A0001};
      repeat (20) @(posedge clk);
      #5 arst_n = 1'b1;
      repeat (4) @(posedge clk);
      host.frame(32'h100, CMD_WR_ONE, 128'h5, 1);
      chk("ack", ack_exp, host.rx[4]);
      chk("locked writes", 0, wr_q.size());
      host.frame(0, CMD_UNLOCK, UNLOCK_W1, 1);
      host.frame(0, CMD_UNLOCK, UNLOCK_W2, 1);
      host.frame(32'h200, CMD_WR_BURST, {32'hF1E2D3C4, 32'hA1B2C3D4}, 2);
      host.frame(32'h300, CMD_WR_ONE, {32'h9, 32'h5A5A0001}, 2);
      chk("write count", 6, wr_q.size());
      foreach (ew[i]) chk("write log", ew[i], wr_q[i]);
      host.frame(32'h400, CMD_RD_BURST, 0, 3);
      for (int k = 0; k < 3; k++)
         chk("burst", 32'(~(32'h400 + 4 * k)), host.rx[k]);
      host.frame(32'h500, CMD_RD_ONE, 0, 1);
      chk("single read", 32'(~32'h500), host.rx[0]);
      host.frame(32'hFFFF_FFFF, CMD_PKT_CNT, 32'hFFFF_8123, 1);
      chk("packets", 15'h0123, pkt_count);
      host.frame(32'h77, CMD_IV, dec_key_fuses, 4);
      chk("vector", dec_key_fuses, init_vector);
      host.frame(32'h88, CMD_SIG, ~dec_key_fuses, 4);
      chk("signature", ~dec_key_fuses, expected_sig);
      host.frame(0, CMD_LD_DEC, 0, 0);
      host.frame(0, CMD_RD_HOLD, 0, 4);
      chk("key", dec_key_fuses, {host.rx[3], host.rx[2], host.rx[1],
          host.rx[0]});
      host.frame(0, CMD_LD_AUTH, 0, 0);
      chk("auth load", auth_key_fuses, fuse_value);
      host.frame(0, CMD_BUF, OPTS, 4);
      host.frame(0, CMD_CP_AUTH, 0, 0);
      chk("auth copy", OPTS, fuse_value);
      host.frame(0, CMD_CP_OPT, 0, 0);
      host.frame(0, CMD_BLOW, 0, 0);
      chk("blown", OPTS, blown);
      chk("box", SBL_BOX_OPT, box);
      for (int b = 1; b >= 0; b--) begin
         @(posedge clk) #5 fuse_busy = b[0];
         host.frame(0, CMD_STATUS, 0, 1);
         chk("status", b, host.rx[0]);
      end
      @(posedge clk) #5 opt_fuses = OPTS;
      host.frame(0, CMD_LD_OPT, 0, 0);
      chk("levels", 3'h7, {secure_mode_fuse, force_extended_signature,
          debug_lock});
      host.frame(0, CMD_RD_HOLD, 0, 4);
      chk("option read", 0, {host.rx[1], host.rx[0]});
      host.frame(32'h500, CMD_RD_ONE, 0, 1);
      chk("ram read", 0, host.rx[0]);
      host.frame(0, CMD_LD_DEC, 0, 0);
      host.frame(0, CMD_RD_HOLD, 0, 4);
      chk("key read", 0, {host.rx[1], host.rx[0]});
      host.frame(0, CMD_CP_DEC, 0, 0);
      chk("key copy", dec_key_fuses, fuse_value);
      host.frame(0, CMD_CP_OPT, 0, 0);
      chk("option copy", SBL_BOX_DEC, fuse_box);
      test_done();
   end
endmodule : sbl_engine_bench
